/* File: spms_pkg.sv */
// Shared constants and types for the serial port block
package spms_pkg;
   localparam int BYTE_W = 8;
   // Control register fields
   localparam int CTL_DONE = 7;
   localparam int CTL_WRITE_COLLISION_FLAG = 6;
   localparam int CTL_MODE_FAULT_FLAG = 5;
   localparam int CTL_MODE_HI = 3;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_PORT_EN = 0;
   localparam logic [7:0] CTL_RST = 8'h04;
   // Configuration register fields
   localparam int CFG_BUSY = 7;
   localparam int CFG_MASTER_ENABLE = 6;
   localparam int CFG_CPHA = 5;
   localparam int CFG_CPOL = 4;
   localparam int CFG_SEL = 3;
   localparam int CFG_NSSIN = 2;
   localparam int CFG_SRMT = 1;
   localparam logic [7:0] CFG_RST = 8'h00;
   // Select modes
   localparam logic [1:0] MODE_3W = 2'h0;
   localparam logic [1:0] MODE_4W_IN = 2'h1;
   // Half clock periods in one byte, and the closing step
   localparam logic [4:0] HALF_END = 5'h10;
   localparam logic [2:0] SLV_LAST = 3'h7;
   localparam int SCK_HALF_DEF = 4;

   typedef enum logic [1:0] {
      SPMS_IDLE = 2'h1,
      SPMS_SHIFT = 2'h2
   } spms_fsm_t;

   typedef struct packed {
      spms_fsm_t fsm;
      logic [7:0] shift;
      logic [7:0] txbuf;
      logic [7:0] rxbuf;
      logic txfull;
      logic rxbit;
      logic sck;
      logic done_f;
      logic write_collision_flag_f;
      logic mode_fault_flag_f;
      logic master_enable;
      logic port_en;
      logic [1:0] mode;
      logic cpha;
      logic cpol;
      logic [4:0] half;
      logic [7:0] div;
      logic [1:0] miso_s;
      logic [1:0] nss_s;
      logic [1:0] tgl_s;
      logic tgl_d;
      logic slv_run;
      logic mosi_oe;
      logic sck_oe;
      logic miso_oe;
      logic nss_o;
      logic nss_oe;
      logic nss_map;
      logic irq;
      logic [7:0] ctl_rd;
      logic [7:0] cfg_rd;
   } spms_st_t;

   typedef struct packed {
      logic [7:0] shift;
      logic [2:0] cnt;
      logic [7:0] rx;
      logic tgl;
   } spms_slv_t;
endpackage

/* File: spms_slv_shift.sv */
// Slave byte shifter on the link clock
`timescale 1ns/1ps
module spms_slv_shift (
   input wire logic i_sck,
   input wire logic i_edge_inv,
   input wire logic i_run,
   input wire logic i_sel_n,
   input wire logic i_mosi,
   input wire logic [7:0] i_tx_byte,
   output logic o_miso,
   output logic [7:0] o_rx_byte,
   output logic o_done_tgl
);
   import spms_pkg::*;

   spms_slv_t s_r;
   spms_slv_t s_nxt;
   logic link_clk;

   // Sampling edge picked by static phase/polarity; change only when idle
   assign link_clk = i_sck ^ i_edge_inv;

   // Shift MSB first; select high means edges are ignored
   always_comb begin
      s_nxt = s_r;
      // Idle edges also settle the toggle, as no reset reaches here;
      // the system side drops any toggle seen while the port is off
      if (!i_run) begin
         s_nxt.cnt = '0;
         s_nxt.shift = i_tx_byte;
         s_nxt.tgl = 1'b0;
      end else if (!i_sel_n) begin
         s_nxt.shift = {s_r.shift[6:0], i_mosi};
         s_nxt.cnt = s_r.cnt + 3'h1;
         if (s_r.cnt == SLV_LAST) begin
            s_nxt.rx = {s_r.shift[6:0], i_mosi};
            s_nxt.tgl = ~s_r.tgl;
            s_nxt.shift = i_tx_byte;
         end
      end
   end

   always_ff @(posedge link_clk) begin
      s_r <= s_nxt;
   end

   // MISO always carries the shift MSB
   assign o_miso = s_r.shift[7];
   assign o_rx_byte = s_r.rx;
   assign o_done_tgl = s_r.tgl;
endmodule

/* File: spms_top.sv */
// Serial port master with select-mode handling
`timescale 1ns/1ps
module spms_top #(
   parameter int SCK_HALF_CYC = spms_pkg::SCK_HALF_DEF
) (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_ctl_wr,
   input wire logic [7:0] i_ctl_wdata,
   input wire logic i_cfg_wr,
   input wire logic [7:0] i_cfg_wdata,
   input wire logic i_dat_wr,
   input wire logic [7:0] i_dat_wdata,
   input wire logic i_int_en,
   input wire logic i_miso,
   input wire logic i_mosi,
   input wire logic i_sck,
   input wire logic i_nss,
   output logic [7:0] o_ctl_rdata,
   output logic [7:0] o_cfg_rdata,
   output logic [7:0] o_dat_rdata,
   output logic o_irq,
   output logic o_mosi,
   output logic o_mosi_oe,
   output logic o_miso,
   output logic o_miso_oe,
   output logic o_sck,
   output logic o_sck_oe,
   output logic o_nss,
   output logic o_nss_oe,
   output logic o_nss_map
);
   import spms_pkg::*;

   spms_st_t s_r;
   spms_st_t s_nxt;
   logic master;
   logic slave;
   logic tick;
   logic slv_miso;
   logic [7:0] slv_rx;
   logic slv_tgl;
   logic slv_sel_n;
   logic [7:0] rx_byte;
   logic fault;

   // Divider must leave room for the two-stage MISO synchroniser
   generate
      if (SCK_HALF_CYC < 3 || SCK_HALF_CYC > 256) begin : g_chk
         $error("SCK_HALF_CYC must lie in 3..256");
      end
   endgenerate

   // Mode decode from registered enables
   assign master = s_r.master_enable & s_r.port_en;
   assign slave = s_r.port_en & ~s_r.master_enable;
   assign tick = (s_r.div == 8'(SCK_HALF_CYC - 1));
   // Phase 1 takes its last bit at the closing step
   assign rx_byte = s_r.cpha ? {s_r.shift[6:0], s_r.rxbit} : s_r.shift;
   // Select only reaches the slave logic in mode 01
   assign slv_sel_n = (s_r.mode == MODE_4W_IN) ? i_nss : 1'b0;
   // Low level taken as the fault, so a missed falling edge still counts
   assign fault = master && s_r.mode == MODE_4W_IN && !s_r.nss_s[1];

   spms_slv_shift u_slv (
      .i_sck(i_sck),
      .i_edge_inv(s_r.cpol ^ s_r.cpha),
      .i_run(s_r.slv_run),
      .i_sel_n(slv_sel_n),
      .i_mosi(i_mosi),
      .i_tx_byte(s_r.txbuf),
      .o_miso(slv_miso),
      .o_rx_byte(slv_rx),
      .o_done_tgl(slv_tgl)
   );

   // Next state: software writes first, hardware events after so sets win
   always_comb begin
      s_nxt = s_r;
      s_nxt.miso_s = {s_r.miso_s[0], i_miso};
      s_nxt.nss_s = {s_r.nss_s[0], i_nss};
      s_nxt.tgl_s = {s_r.tgl_s[0], slv_tgl};
      s_nxt.tgl_d = s_r.tgl_s[1];
      // Control writes: flags clear on 0, cannot be set by software
      if (i_ctl_wr) begin
         s_nxt.mode = i_ctl_wdata[CTL_MODE_HI:CTL_MODE_LO];
         s_nxt.port_en = i_ctl_wdata[CTL_PORT_EN];
         s_nxt.done_f = s_r.done_f & i_ctl_wdata[CTL_DONE];
         s_nxt.write_collision_flag_f = s_r.write_collision_flag_f & i_ctl_wdata[CTL_WRITE_COLLISION_FLAG];
         s_nxt.mode_fault_flag_f = s_r.mode_fault_flag_f & i_ctl_wdata[CTL_MODE_FAULT_FLAG];
      end
      if (i_cfg_wr) begin
         s_nxt.master_enable = i_cfg_wdata[CFG_MASTER_ENABLE];
         s_nxt.cpha = i_cfg_wdata[CFG_CPHA];
         s_nxt.cpol = i_cfg_wdata[CFG_CPOL];
      end
      // Buffer still full: write dropped, collision flagged
      if (i_dat_wr) begin
         if (s_r.txfull) begin
            s_nxt.write_collision_flag_f = 1'b1;
         end else begin
            s_nxt.txbuf = i_dat_wdata;
            s_nxt.txfull = 1'b1;
         end
      end
      // Master sequencer
      unique case (s_r.fsm)
         SPMS_IDLE: begin
            s_nxt.sck = s_r.cpol;
            s_nxt.div = '0;
            s_nxt.half = '0;
            if (master && s_r.txfull) begin
               s_nxt.shift = s_r.txbuf;
               s_nxt.txfull = 1'b0;
               s_nxt.fsm = SPMS_SHIFT;
            end
         end
         SPMS_SHIFT: begin
            s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
            if (tick && s_r.half != HALF_END) begin
               s_nxt.sck = ~s_r.sck;
               s_nxt.half = s_r.half + 5'h01;
               if (s_r.half[0] == s_r.cpha) begin
                  s_nxt.rxbit = s_r.miso_s[1];
               end
               if (s_r.cpha ? (!s_r.half[0] && s_r.half != 5'h00)
                            : s_r.half[0]) begin
                  s_nxt.shift = {s_r.shift[6:0], s_r.rxbit};
               end
            end else if (tick) begin
               // Sixteen edges done, clock back at idle level
               s_nxt.shift = rx_byte;
               s_nxt.rxbuf = rx_byte;
               s_nxt.done_f = 1'b1;
               s_nxt.fsm = SPMS_IDLE;
            end
            if (!master) begin
               s_nxt.sck = s_r.cpol;
               s_nxt.fsm = SPMS_IDLE;
            end
         end
      endcase
      // Slave byte finished in the link domain
      if (slave && (s_r.tgl_s[1] ^ s_r.tgl_d)) begin
         s_nxt.rxbuf = slv_rx;
         s_nxt.done_f = 1'b1;
         s_nxt.txfull = 1'b0;
      end
      // Another master pulled select low: give up the bus
      if (fault) begin
         s_nxt.master_enable = 1'b0;
         s_nxt.port_en = 1'b0;
         s_nxt.mode_fault_flag_f = 1'b1;
         s_nxt.fsm = SPMS_IDLE;
         s_nxt.sck = s_r.cpol;
      end
      // Registered pin controls, decoded from the next state
      s_nxt.slv_run = s_nxt.port_en & ~s_nxt.master_enable;
      s_nxt.mosi_oe = s_nxt.port_en & s_nxt.master_enable;
      s_nxt.sck_oe = s_nxt.port_en & s_nxt.master_enable;
      s_nxt.miso_oe = s_nxt.slv_run & (s_nxt.mode != MODE_4W_IN ||
                      !s_r.nss_s[1]);
      s_nxt.nss_oe = s_nxt.mode[1];
      s_nxt.nss_o = s_nxt.mode[1] ? s_nxt.mode[0] : 1'b1;
      s_nxt.nss_map = (s_nxt.mode != MODE_3W);
      s_nxt.irq = i_int_en & (s_nxt.done_f | s_nxt.write_collision_flag_f |
                  s_nxt.mode_fault_flag_f);
      s_nxt.ctl_rd = '0;
      s_nxt.ctl_rd[CTL_DONE] = s_nxt.done_f;
      s_nxt.ctl_rd[CTL_WRITE_COLLISION_FLAG] = s_nxt.write_collision_flag_f;
      s_nxt.ctl_rd[CTL_MODE_FAULT_FLAG] = s_nxt.mode_fault_flag_f;
      s_nxt.ctl_rd[CTL_MODE_HI:CTL_MODE_LO] = s_nxt.mode;
      s_nxt.ctl_rd[CTL_PORT_EN] = s_nxt.port_en;
      s_nxt.cfg_rd = '0;
      s_nxt.cfg_rd[CFG_BUSY] = (s_nxt.fsm == SPMS_SHIFT);
      s_nxt.cfg_rd[CFG_MASTER_ENABLE] = s_nxt.master_enable;
      s_nxt.cfg_rd[CFG_CPHA] = s_nxt.cpha;
      s_nxt.cfg_rd[CFG_CPOL] = s_nxt.cpol;
      s_nxt.cfg_rd[CFG_SEL] = s_nxt.slv_run & s_nxt.miso_oe;
      s_nxt.cfg_rd[CFG_NSSIN] = s_r.nss_s[1];
      s_nxt.cfg_rd[CFG_SRMT] = (s_nxt.fsm == SPMS_IDLE);
   end

   // State register with synchronous reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         s_r <= '0;
         s_r.fsm <= SPMS_IDLE;
         s_r.mode <= CTL_RST[CTL_MODE_HI:CTL_MODE_LO];
         s_r.miso_s <= 2'h3;
         s_r.nss_s <= 2'h3;
         s_r.nss_o <= 1'b1;
         s_r.nss_map <= 1'b1;
         s_r.ctl_rd <= CTL_RST;
         s_r.cfg_rd <= CFG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops; MISO from the link-domain flop
   assign o_ctl_rdata = s_r.ctl_rd;
   assign o_cfg_rdata = s_r.cfg_rd;
   assign o_dat_rdata = s_r.rxbuf;
   assign o_irq = s_r.irq;
   assign o_mosi = s_r.shift[7];
   assign o_mosi_oe = s_r.mosi_oe;
   assign o_miso = slv_miso;
   assign o_miso_oe = s_r.miso_oe;
   assign o_sck = s_r.sck;
   assign o_sck_oe = s_r.sck_oe;
   assign o_nss = s_r.nss_o;
   assign o_nss_oe = s_r.nss_oe;
   assign o_nss_map = s_r.nss_map;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);

   // Checks on the master sequencer and pin control
   start_load_a: assert property (
      (s_r.fsm == SPMS_IDLE && master && s_r.txfull && !fault) |=>
      (s_r.fsm == SPMS_SHIFT && s_r.shift == $past(s_r.txbuf)))
      else $error("transfer did not start from buffer");
   done_idle_a: assert property (
      (s_r.fsm == SPMS_SHIFT && tick && s_r.half == HALF_END && master)
      |=> (o_sck == s_r.cpol && s_r.done_f && s_r.fsm == SPMS_IDLE))
      else $error("byte end wrong");
   irq_flag_a: assert property (
      ($past(i_int_en) && s_r.done_f) |-> o_irq)
      else $error("interrupt missing for done flag");
   miso_float_a: assert property (
      (!s_r.port_en || s_r.master_enable) |-> !o_miso_oe)
      else $error("MISO driven while disabled");
   nss_drive_a: assert property (
      s_r.mode[1] |-> (o_nss_oe && o_nss == s_r.mode[0]))
      else $error("select output level wrong");
   nss_route_a: assert property (
      (s_r.mode == MODE_3W) |-> (!o_nss_map && !o_nss_oe))
      else $error("select routed in 3-wire mode");
   mode_fault_a: assert property (
      (master && s_r.mode == MODE_4W_IN && !s_r.nss_s[1]) |=>
      (!s_r.master_enable && !s_r.port_en && s_r.mode_fault_flag_f && !o_sck_oe))
      else $error("mode fault not taken");
   wr_collide_a: assert property (
      (i_dat_wr && s_r.txfull) |=>
      (s_r.write_collision_flag_f && s_r.txbuf == $past(s_r.txbuf)))
      else $error("collision write not ignored");
   sck_master_a: assert property (
      !master |-> !o_sck_oe)
      else $error("SCK driven outside master mode");
   // Pin and flag checks that the tests reach only in passing
   miso_unsel_a: assert property (
      (s_r.mode == MODE_4W_IN && $past(s_r.nss_s[1])) |-> !o_miso_oe)
      else $error("MISO driven while not selected");
   nss_idle_a: assert property (
      !s_r.mode[1] |-> o_nss)
      else $error("select output not idle high");
   port_hold_a: assert property (
      (!s_r.port_en && !i_ctl_wr) |=> !s_r.port_en)
      else $error("port enabled without software");
   irq_fault_a: assert property (
      ($past(i_int_en) && s_r.mode_fault_flag_f) |-> o_irq)
      else $error("interrupt missing for mode fault");
   buf_load_a: assert property (
      (i_dat_wr && !s_r.txfull) |=> (s_r.txbuf == $past(i_dat_wdata)))
      else $error("data write not buffered");
   // Byte sequencing: one clock edge per tick, capture at the end
   sck_toggle_a: assert property (
      (s_r.fsm == SPMS_SHIFT && master && !fault && tick &&
       s_r.half != HALF_END) |=> (o_sck != $past(o_sck)))
      else $error("SCK did not toggle on tick");
   busy_flag_a: assert property (
      (s_r.fsm == SPMS_SHIFT) |-> o_cfg_rdata[CFG_BUSY])
      else $error("busy flag low while shifting");
   half_range_a: assert property (
      s_r.half <= HALF_END)
      else $error("more than sixteen clock edges");
   rx_done_a: assert property (
      (s_r.fsm == SPMS_SHIFT && master && tick && s_r.half == HALF_END)
      |=> (o_dat_rdata == $past(rx_byte)))
      else $error("received byte not buffered");

   done_c: cover property (s_r.fsm == SPMS_SHIFT ##1 $rose(s_r.done_f));
   fault_c: cover property ($rose(s_r.mode_fault_flag_f));
   collide_c: cover property ($rose(s_r.write_collision_flag_f));
   slave_c: cover property (slave && (s_r.tgl_s[1] ^ s_r.tgl_d));
endmodule

/* File: spms_slave_model.sv */
// Behavioural slave device facing the master port
`timescale 1ns/1ps
module spms_slave_model (
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_load,
   input wire logic [7:0] i_tx,
   output logic o_miso,
   output logic [7:0] o_rx
);
   logic [7:0] sh;
   int falls;
   // Sole slave on the wire, idle clock low, leading edge samples
   initial begin
      o_miso = 1'b0;
      o_rx = 8'h00;
      sh = 8'h00;
      falls = 0;
   end
   // Preload shows the first bit before the first edge
   always @(posedge i_load) begin
      sh = i_tx;
      o_miso = i_tx[7];
      falls = 0;
   end
   // Master data taken MSB first on the leading edge
   always @(posedge i_sck) begin
      o_rx = {o_rx[6:0], i_mosi};
   end
   // Next bit on the trailing edge; inverted once released
   always @(negedge i_sck) begin
      sh = {sh[6:0], 1'b0};
      falls++;
      o_miso = (falls < 8) ? sh[7] : ~o_miso;
   end
endmodule

/* File: spi_master_and_select_modes_tb.sv */
// Self-checking bench for the serial port master and select modes
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
$display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module spi_master_and_select_modes_tb;
   import spms_pkg::*;
   logic i_mclk, i_rst_b, i_ctl_wr, i_cfg_wr, i_dat_wr, i_int_en;
   logic [7:0] i_ctl_wdata, i_cfg_wdata, i_dat_wdata, ld_byte, m_rx;
   logic [7:0] o_ctl_rdata, o_cfg_rdata, o_dat_rdata;
   logic i_mosi, i_sck, i_nss, ld, m_miso, o_irq, o_mosi, o_mosi_oe;
   logic o_miso, o_miso_oe, o_sck, o_sck_oe, o_nss, o_nss_oe, o_nss_map;
   int fail_count, checked, cycles, rises;

   spms_top #(.SCK_HALF_CYC(3)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .i_cfg_wr(i_cfg_wr),
      .i_cfg_wdata(i_cfg_wdata), .i_dat_wr(i_dat_wr),
      .i_dat_wdata(i_dat_wdata), .i_int_en(i_int_en), .i_miso(m_miso),
      .i_mosi(i_mosi), .i_sck(i_sck), .i_nss(i_nss),
      .o_ctl_rdata(o_ctl_rdata), .o_cfg_rdata(o_cfg_rdata),
      .o_dat_rdata(o_dat_rdata), .o_irq(o_irq), .o_mosi(o_mosi),
      .o_mosi_oe(o_mosi_oe), .o_miso(o_miso), .o_miso_oe(o_miso_oe),
      .o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_nss(o_nss),
      .o_nss_oe(o_nss_oe), .o_nss_map(o_nss_map));
   spms_slave_model partner (.i_sck(o_sck), .i_mosi(o_mosi), .i_load(ld),
      .i_tx(ld_byte), .o_miso(m_miso), .o_rx(m_rx));

   // System clock, 50 ns
   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   // Serial clock edges driven by the port
   always @(posedge o_sck) rises++;
   // Ceiling well above the few hundred cycles the run needs
   always @(posedge i_mclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("unexpected at %0t: run hung", $time);
         end_of_test();
      end
   end

   task automatic end_of_test;
      if (fail_count == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #5;
   endtask
   // One-cycle write strobe: 0 control, 1 config, 2 data
   task automatic wr(input int sel, input logic [7:0] d);
      @(posedge i_mclk);
      #5;
      i_ctl_wdata = d;
      i_cfg_wdata = d;
      i_dat_wdata = d;
      i_ctl_wr = (sel == 0);
      i_cfg_wr = (sel == 1);
      i_dat_wr = (sel == 2);
      tick(1);
      i_ctl_wr = 1'b0;
      i_cfg_wr = 1'b0;
      i_dat_wr = 1'b0;
   endtask
   // Bounded wait for the done flag
   task automatic wait_done;
      int n;
      n = 0;
      while (o_ctl_rdata[CTL_DONE] !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
   endtask
   // One byte on the link clock, 160 ns period, stopped outside
   task automatic frame(input logic [7:0] b);
      #7;
      for (int i = 7; i >= 0; i--) begin
         i_mosi = b[i];
         #80 i_sck = 1'b1;
         #80 i_sck = 1'b0;
      end
      i_mosi = ~i_mosi;
      tick(4);
   endtask

   task automatic t_reset;
      `CHK(o_ctl_rdata, CTL_RST)
      `CHK(o_cfg_rdata, CFG_RST)
      `CHK({o_mosi_oe, o_sck_oe, o_miso_oe, o_nss_oe}, 4'h0)
      `CHK({o_nss_map, o_sck}, 2'h2)
   endtask
   // Select output mode, full byte each way
   task automatic t_master;
      // Link clock runs once with the port off to settle the shifter
      frame(8'h00);
      `CHK(o_ctl_rdata[CTL_DONE], 1'b0)
      i_int_en = 1'b1;
      wr(1, 8'h40);
      wr(0, 8'h0d);
      `CHK({o_nss_oe, o_nss, o_nss_map}, 3'h7)
      `CHK({o_mosi_oe, o_sck_oe}, 2'h3)
      ld_byte = 8'h3c;
      ld = 1'b1;
      rises = 0;
      wr(2, 8'ha5);
      ld = 1'b0;
      tick(2);
      `CHK(o_cfg_rdata[CFG_BUSY], 1'b1)
      wait_done;
      tick(1);
      `CHK(o_ctl_rdata[CTL_DONE], 1'b1)
      `CHK(o_irq, 1'b1)
      `CHK(rises, 8)
      `CHK(o_sck, 1'b0)
      `CHK(m_rx, 8'ha5)
      `CHK(o_dat_rdata, 8'h3c)
      wr(0, 8'h0d);
      tick(1);
      `CHK(o_irq, 1'b0)
   endtask
   // Third write while the buffer still holds the second
   task automatic t_collide;
      wr(2, 8'h11);
      tick(2);
      wr(2, 8'h22);
      wr(2, 8'h33);
      tick(1);
      `CHK(o_ctl_rdata[CTL_WRITE_COLLISION_FLAG], 1'b1)
      wait_done;
      wr(0, 8'h4d);
      tick(1);
      wait_done;
      `CHK(m_rx, 8'h22)
      wr(0, 8'h0d);
      tick(2);
      `CHK({o_ctl_rdata[7:5], o_irq}, 4'h0)
   endtask
   // Another master pulls select low
   task automatic t_fault;
      wr(0, 8'h05);
      `CHK({o_nss_oe, o_nss_map, o_sck_oe}, 3'h3)
      i_nss = 1'b0;
      tick(4);
      `CHK(o_ctl_rdata[CTL_MODE_FAULT_FLAG], 1'b1)
      `CHK(o_ctl_rdata[CTL_PORT_EN], 1'b0)
      `CHK({o_cfg_rdata[CFG_MASTER_ENABLE], o_sck_oe}, 2'h0)
      `CHK(o_irq, 1'b1)
      i_nss = 1'b1;
      tick(4);
      `CHK(o_ctl_rdata[CTL_PORT_EN], 1'b0)
      wr(0, 8'h05);
      tick(3);
      `CHK(o_miso_oe, 1'b0)
      i_nss = 1'b0;
      tick(4);
      `CHK(o_miso_oe, 1'b1)
      i_nss = 1'b1;
      tick(4);
   endtask
   // Slave: unselected edges ignored, then 3-wire byte
   task automatic t_slave;
      i_int_en = 1'b0;
      frame(8'hc3);
      `CHK(o_ctl_rdata[CTL_DONE], 1'b0)
      wr(0, 8'h04);
      wr(0, 8'h01);
      `CHK({o_nss_map, o_nss_oe, o_sck_oe}, 3'h0)
      wr(2, 8'h96);
      `CHK(o_miso_oe, 1'b1)
      frame(8'h5a);
      `CHK(o_miso, 1'b1)
      `CHK(o_ctl_rdata[CTL_DONE], 1'b1)
      `CHK(o_dat_rdata, 8'h5a)
      `CHK(o_irq, 1'b0)
   endtask

   // Main sequence
   initial begin
      fail_count = 0;
      checked = 0;
      cycles = 0;
      rises = 0;
      i_rst_b = 1'b0;
      {i_ctl_wr, i_cfg_wr, i_dat_wr, i_int_en, i_mosi, i_sck, ld} = 7'h00;
      {i_ctl_wdata, i_cfg_wdata, i_dat_wdata, ld_byte} = 32'h0000_0000;
      i_nss = 1'b1;
      tick(20);
      t_reset();
      i_rst_b = 1'b1;
      t_master();
      t_collide();
      t_fault();
      t_slave();
      end_of_test();
   end
endmodule
